// File: stdc_pkg.sv
package stdc_pkg;

    // ****************************************
    // Widths and field layout
    // ****************************************
    localparam int          STDC_CNT_W       = 24;
    localparam logic [23:0] STDC_RELOAD_MAX  = 24'hffffff;
    localparam logic [23:0] STDC_CNT_ZERO    = 24'h000000;
    localparam int          STDC_CSR_W       = 32;
    localparam int          STDC_EN_POS      = 0;
    localparam int          STDC_TICKIE_POS  = 1;
    localparam int          STDC_CLKSEL_POS  = 2;
    localparam int          STDC_FLAG_POS    = 16;
    localparam logic [31:0] STDC_CSR_RESET   = 32'h00000000;
    localparam int          STDC_SYNC_STAGES = 3;

    // ****************************************
    // Control carrier
    // ****************************************
    typedef struct packed {
        logic tick_clock_select;
        logic tick_irq_enable;
        logic enable;
    } stdc_ctrl_type;

endpackage : stdc_pkg

// File: stdc_edge_sync.sv
`timescale 1ns/1ps

module stdc_edge_sync
    import stdc_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output logic      rise_o
);

    // ****************************************
    // Three-stage synchroniser
    // ****************************************
    logic [STDC_SYNC_STAGES-1:0] sync_reg;
    logic                        level_reg;
    wire                         agree = (sync_reg[1] == sync_reg[2]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_reg  <= '0;
            level_reg <= 1'b0;
            rise_o    <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[1:0], async_i};
            // Only stages two and three vote, stage one stays private
            if (agree) begin
                level_reg <= sync_reg[2];
            end
            rise_o <= agree & sync_reg[2] & ~level_reg;
        end
    end

endmodule : stdc_edge_sync

// File: stdc_timer.sv
`timescale 1ns/1ps
// Summary of operation
// - 24-bit down counter wrapping back to the reload value after zero.
// - Enabled: counts to zero, reloads next step, continues decrementing.
// - Reload of zero stops counting at the next wrap.
// - Reaching zero sets the sticky wrap-seen flag.
// - Reading control/status returns the flag, then clears it.
// - Any write to current value clears counter and flag.
// - Clearing by that write raises no interrupt.
// - Current value read returns the counter as of that cycle.
// - Debug halt freezes the counter.
// - Steps on core clock or external reference clock edges.
// - Control/status holds clock select, enable, interrupt enable, status.
// - No calibration register exists.
// - Enable one: load, count, flag, reload repeatedly; zero stops.
// - Interrupt enable one: reaching zero pends the tick exception.
// - Reload accepts 1 to 0xffffff, period reload plus one.
// - Reset clears control/status to zero.

module stdc_timer
    import stdc_pkg::*;
#(
    parameter int CNT_W = STDC_CNT_W
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  csr_wr_i,
    input  wire logic [STDC_CSR_W-1:0] csr_wdata_i,
    input  wire logic                  csr_rd_i,
    input  wire logic                  reload_wr_i,
    input  wire logic [CNT_W-1:0]      reload_wdata_i,
    input  wire logic                  cur_wr_i,
    input  wire logic                  cur_rd_i,
    input  wire logic                  debug_halt_i,
    input  wire logic                  ext_ref_clk_i,
    output logic [STDC_CSR_W-1:0]      csr_rdata_o,
    output logic [CNT_W-1:0]           reload_o,
    output logic [CNT_W-1:0]           cur_rdata_o,
    output logic                       wrap_seen_flag_o,
    output logic                       tick_irq_o
);

    // ****************************************
    // Elaboration check
    // ****************************************
    if (CNT_W != STDC_CNT_W) begin : g_bad_width
        $error("stdc_timer: counter width fixed by register layout");
    end

    // Every control and status field must land inside the register word
    if (STDC_FLAG_POS >= STDC_CSR_W || STDC_CLKSEL_POS >= STDC_CSR_W ||
        STDC_TICKIE_POS >= STDC_CSR_W || STDC_EN_POS >= STDC_CSR_W) begin : g_bad_layout
        $error("stdc_timer: status field outside the register word");
    end

    if (STDC_SYNC_STAGES != 3) begin : g_bad_sync
        $error("stdc_timer: synchroniser is built for three stages");
    end

    // ****************************************
    // Field decoding
    // ****************************************
    // Reset and software writes share one unpacking of the control bits
    function automatic stdc_ctrl_type ctrl_from_word(input logic [STDC_CSR_W-1:0] word);
        stdc_ctrl_type ctrl;
        ctrl.enable            = word[STDC_EN_POS];
        ctrl.tick_irq_enable   = word[STDC_TICKIE_POS];
        ctrl.tick_clock_select = word[STDC_CLKSEL_POS];
        return ctrl;
    endfunction : ctrl_from_word

    // ****************************************
    // State
    // ****************************************
    stdc_ctrl_type    ctrl_reg;
    logic             flag_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] reload_reg;
    logic             ext_rise;

    // ****************************************
    // Reference clock selection
    // ****************************************
    stdc_edge_sync u_ext_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (ext_ref_clk_i),
        .rise_o  (ext_rise)
    );

    // Select one: core clock; zero: external edges
    wire ref_step = ctrl_reg.tick_clock_select ? 1'b1 : ext_rise;
    wire step     = ctrl_reg.enable & ref_step & ~debug_halt_i;
    wire at_zero  = (count_reg == STDC_CNT_ZERO);

    // ****************************************
    // Counter next value
    // ****************************************
    // A zero reload idles at zero with no further events
    wire reach_zero = step & ~cur_wr_i & (count_reg == CNT_W'(1));
    wire do_wrap    = step & ~cur_wr_i & at_zero;

    wire [CNT_W-1:0] count_next =
        cur_wr_i   ? STDC_CNT_ZERO :
        do_wrap    ? reload_reg :
        (step & ~at_zero) ? count_reg - CNT_W'(1) :
        count_reg;

    // ****************************************
    // Wrap-seen flag
    // ****************************************
    // Set wins over the read clear; write clear wins since it zeroes too
    wire flag_next = cur_wr_i ? 1'b0 :
                     reach_zero ? 1'b1 :
                     csr_rd_i ? 1'b0 : flag_reg;

    // ****************************************
    // Status word
    // ****************************************
    // Reserved bits read as zero so read-modify-write by software stays harmless
    wire logic [STDC_CSR_W-1:0] csr_view;
    for (genvar b = 0; b < STDC_CSR_W; b++) begin : g_csr_bit
        if (b == STDC_FLAG_POS) begin : g_flag
            assign csr_view[b] = flag_reg;
        end else if (b == STDC_CLKSEL_POS) begin : g_clksel
            assign csr_view[b] = ctrl_reg.tick_clock_select;
        end else if (b == STDC_TICKIE_POS) begin : g_tickie
            assign csr_view[b] = ctrl_reg.tick_irq_enable;
        end else if (b == STDC_EN_POS) begin : g_en
            assign csr_view[b] = ctrl_reg.enable;
        end else begin : g_rsvd
            assign csr_view[b] = 1'b0;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= ctrl_from_word(STDC_CSR_RESET);
        end else if (csr_wr_i) begin
            ctrl_reg <= ctrl_from_word(csr_wdata_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reload_reg <= STDC_CNT_ZERO;
        end else if (reload_wr_i) begin
            reload_reg <= reload_wdata_i & STDC_RELOAD_MAX;
        end
    end

    // Flag and counter update every clock; the next-value logic owns the priorities
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= STDC_CNT_ZERO;
        end else begin
            count_reg <= count_next;
        end
    end

    // ****************************************
    // Read data and event outputs
    // ****************************************
    wire irq_event = reach_zero & ctrl_reg.tick_irq_enable;

    // Read data registered from the accessed cycle's state, held until the next read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            csr_rdata_o <= STDC_CSR_RESET;
        end else if (csr_rd_i) begin
            csr_rdata_o <= csr_view;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_rdata_o <= STDC_CNT_ZERO;
        end else if (cur_rd_i) begin
            cur_rdata_o <= count_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reload_o <= STDC_CNT_ZERO;
        end else begin
            reload_o <= reload_reg;
        end
    end

    // Flag output follows the next value so it lines up with the internal flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wrap_seen_flag_o <= 1'b0;
        end else begin
            wrap_seen_flag_o <= flag_next;
        end
    end

    // One-cycle pulse; a clearing write never reaches it since reach_zero excludes it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_irq_o <= 1'b0;
        end else begin
            tick_irq_o <= irq_event;
        end
    end

    // No calibration register port exists

endmodule : stdc_timer

// File: stdc_timer_asserts.sv
`timescale 1ns/1ps
module stdc_timer_chk
    import stdc_pkg::*;
#(
    parameter int CNT_W = STDC_CNT_W
) (
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    input wire logic                  csr_rd_i,
    input wire logic                  reload_wr_i,
    input wire logic [CNT_W-1:0]      reload_wdata_i,
    input wire logic                  cur_wr_i,
    input wire logic [STDC_CSR_W-1:0] csr_rdata_o,
    input wire logic [CNT_W-1:0]      reload_o,
    input wire logic                  wrap_seen_flag_o,
    input wire logic                  tick_irq_o
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_irq_one_cycle: assert property (tick_irq_o |=> !tick_irq_o)
        else $error("irq longer than one cycle");
    a_wrclr_flag: assert property (cur_wr_i |=> !wrap_seen_flag_o)
        else $error("flag kept after clear write");
    // Neither of the two cycles after the clearing write may carry a pulse
    a_wrclr_no_irq: assert property (cur_wr_i |=> (!tick_irq_o) [*2])
        else $error("irq after clear write");
    a_rd_flag: assert property (csr_rd_i |=> csr_rdata_o[16] == $past(wrap_seen_flag_o))
        else $error("read flag wrong");
    a_rd_reserved: assert property (csr_rd_i |=> csr_rdata_o[31:17] == 0 && csr_rdata_o[15:3] == 0)
        else $error("reserved bits set");
    a_reload_copy: assert property (reload_wr_i |-> ##2 reload_o == $past(reload_wdata_i, 2))
        else $error("reload not stored");
    a_flag_sticky: assert property ($fell(wrap_seen_flag_o) |-> $past(csr_rd_i || cur_wr_i))
        else $error("flag fell alone");
    a_irq_flag: assert property ($rose(tick_irq_o) |-> wrap_seen_flag_o || $past(csr_rd_i))
        else $error("irq without flag");
endmodule : stdc_timer_chk
bind stdc_timer stdc_timer_chk #(.CNT_W(CNT_W)) i_chk (.clk_i, .rst_i, .csr_rd_i, .reload_wr_i,
    .reload_wdata_i, .cur_wr_i, .csr_rdata_o, .reload_o, .wrap_seen_flag_o, .tick_irq_o);

// File: system_tick_down_counter_tb_top.sv
`timescale 1ns/1ps
module system_tick_down_counter_tb_top;
    import stdc_pkg::*;
    logic        clk_i = 0, rst_i = 1, cw = 0, cr = 0, rw = 0, uw = 0, ur = 0, dh = 0, ek = 0;
    logic [31:0] wd = '0, csr;
    logic [23:0] rl, cur;
    logic        flg, irq;
    int          fail_count = 0, tests_run = 0;
    always #2.5 clk_i = ~clk_i;
    stdc_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .csr_wr_i(cw), .csr_wdata_i(wd),
        .csr_rd_i(cr), .reload_wr_i(rw), .reload_wdata_i(wd[23:0]), .cur_wr_i(uw),
        .cur_rd_i(ur), .debug_halt_i(dh), .ext_ref_clk_i(ek), .csr_rdata_o(csr),
        .reload_o(rl), .cur_rdata_o(cur), .wrap_seen_flag_o(flg), .tick_irq_o(irq));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Strobe k: 0 csr write, 1 csr read, 2 reload write, 3 cur write, 4 cur read
    task automatic strobe(input int k, input logic [31:0] d);
        @(posedge clk_i);
        wd <= d;
        {cw, cr, rw, uw, ur} <= 5'h10 >> k;
        @(posedge clk_i);
        {cw, cr, rw, uw, ur} <= 5'h00;
        @(posedge clk_i);
    endtask : strobe
    task automatic wait_irq(output int n);
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge clk_i);
            n++;
            if (n > 200) begin
                fail_count++;
                $display("mismatch at %0t: no tick interrupt", $time);
                test_done();
            end
        end
    endtask : wait_irq
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_period();
        int n;
        strobe(1, 0);
        chk(csr, STDC_CSR_RESET);
        strobe(2, 40);
        @(posedge clk_i);
        chk(rl, 40);
        strobe(0, 7);
        wait_irq(n);
        @(posedge clk_i);
        wait_irq(n);
        chk(n + 1, 41);
        strobe(1, 0);
        chk(csr, 32'h00010007);
        strobe(1, 0);
        chk(csr[16], 0);
        wait_irq(n);
        strobe(3, 0);
        chk(flg, 0);
    endtask : t_period
    task automatic t_halt();
        logic [23:0] v;
        dh <= 1;
        strobe(4, 0);
        v = cur;
        repeat (20) @(posedge clk_i);
        strobe(4, 0);
        chk(cur, v);
        dh <= 0;
        strobe(4, 0);
        chk(cur, v - 24'h000001);
    endtask : t_halt
    task automatic t_ext();
        logic seen;
        seen = 0;
        strobe(0, 1);
        strobe(3, 0);
        for (int i = 0; i < 82; i++) begin
            repeat (4) begin
                @(posedge clk_i);
                seen |= irq;
            end
            ek <= ~ek;
            if (i == 80) chk(flg, 0);
        end
        repeat (8) @(posedge clk_i);
        chk(flg, 1);
        chk(seen, 0);
    endtask : t_ext
    task automatic t_stop();
        int n;
        strobe(0, 7);
        strobe(2, 0);
        wait_irq(n);
        repeat (100) @(posedge clk_i);
        strobe(1, 0);
        repeat (100) @(posedge clk_i);
        strobe(1, 0);
        chk(csr[16], 0);
        strobe(4, 0);
        chk(cur, 0);
    endtask : t_stop
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        t_period();
        t_halt();
        t_ext();
        t_stop();
        test_done();
    end
endmodule : system_tick_down_counter_tb_top
